// ### bench/atc_checker.sv
// Port assertions for the converter trigger and power control block
`timescale 1ns/1ps
`default_nettype none

module atc_checker
   import atc_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         rst,
   input wire atc_avs_req_t avs_req,
   input wire logic [31:0]  avs_readdata,
   input wire logic         avs_waitrequest,
   input wire logic         stop_mode,
   input wire logic         wait_mode,
   input wire logic         irq,
   input wire logic         conv_active,
   input wire logic [2:0]   conv_channel
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Activity seen just before stop mode, frozen while stop mode lasts
   logic run_held_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         run_held_q <= 1'b0;
      end else if (!stop_mode) begin
         run_held_q <= conv_active;
      end
   end

   // A resume after a halt re-raises activity mid-sequence, so it is excluded
   sequence fresh_start_s;
      $rose(conv_active) && !$past(stop_mode) && !$past(wait_mode);
   endsequence
   sequence chan0_run_s;
      (conv_active && conv_channel == 3'h0) [*8] ##1 conv_channel == 3'h1;
   endsequence
   ////////////////////////////////////////
   wait_one_a: assert property ($rose(avs_req.read || avs_req.write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait");
   idle_nowait_a: assert property (!(avs_req.read || avs_req.write) |-> !avs_waitrequest)
      else $error("wait raised with no request");
   rdata_hold_a: assert property (!avs_req.read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   rst_quiet_a: assert property ($fell(rst) |-> !irq && !conv_active)
      else $error("active after reset");
   seq_start_a: assert property (fresh_start_s |-> chan0_run_s)
      else $error("sequence did not start on channel 0");
   chan_step_a: assert property (conv_active && $past(conv_active) && conv_channel != $past(conv_channel)
                                 |-> conv_channel == $past(conv_channel) + 3'h1)
      else $error("channel skipped");
   stop_halt_a: assert property (stop_mode |-> !conv_active)
      else $error("conversion runs in stop mode");
   halt_resume_a: assert property ($fell(stop_mode) && run_held_q && !wait_mode |-> conv_active)
      else $error("conversion not resumed");
endmodule : atc_checker

bind atc_top atc_checker u_chk (.clk_sys, .rst, .avs_req, .avs_readdata, .avs_waitrequest,
                                .stop_mode, .wait_mode, .irq, .conv_active, .conv_channel);
`default_nettype wire

// ### bench/atc_pin_model.sv
// Pad model driving the analog pins from levels the bench commands
`timescale 1ns/1ps
`default_nettype none

module atc_pin_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] pin_cmd,
   output logic [7:0]      an_pin
);
   // Pads are always driven, so no released level to model
   always_ff @(posedge clk_sys) begin
      an_pin <= pin_cmd;
   end
endmodule : atc_pin_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the converter trigger and power control block
`timescale 1ns/1ps
`default_nettype none

module tb
   import atc_pkg::*;
();
   logic         clk_sys;
   logic         rst;
   atc_avs_req_t avs_req;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic [7:0]   pin_cmd;
   logic [7:0]   an_pin;
   logic         stop_mode;
   logic         wait_mode;
   logic         irq;
   logic         conv_active;
   logic [2:0]   conv_channel;
   logic         conv_result_meaningful;
   int           num_errors;
   int           cmp_count;

   atc_top DUT (.clk_sys, .rst, .avs_req, .avs_readdata, .avs_waitrequest, .an_pin, .stop_mode,
                .wait_mode, .irq, .conv_active, .conv_channel, .conv_result_meaningful);
   atc_pin_model u_pins (.clk_sys, .pin_cmd, .an_pin);

   always #50 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task chk1(input logic got, input logic exp);
      chk({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask : chk1

   // Request held until waitrequest is seen low at a rising edge
   task bus(input bit w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      avs_req <= '{read: !w, write: w, address: a, writedata: d};
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_req <= '0;
      @(posedge clk_sys);
   endtask : bus

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask : rd

   task t_reset();
      rd(OFF_CTRL, 32'h0, 32'h3F);
      rd(OFF_TRIG_SRC, 32'h7, 32'h7);
      rd(OFF_PORT, 32'hFF, 32'hFF);
      rd(OFF_STATUS, 32'h0, 32'h7);
      wr(OFF_TRIG_SRC, 32'h3);
      rd(OFF_TRIG_SRC, 32'h3, 32'h7);
      wr(OFF_TRIG_SRC, 32'h7);
      pin_cmd <= 8'h00;
      wr(OFF_DIEN, 32'h0F);
      cyc(8);
      rd(OFF_PORT, 32'hF0, 32'hFF);
      wr(OFF_CTRL, 32'h04);
      wr(OFF_DIEN, 32'h00);
      cyc(2);
      rd(OFF_PORT, 32'h7F, 32'hFF);
      wr(OFF_CTRL, 32'h0);
      pin_cmd <= 8'hFF;
      cyc(8);
      $display("reset and port test done");
   endtask : t_reset

   task t_soft();
      wr(OFF_IRQ_EN, 32'h1);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_START, 32'h0);
      cyc(70);
      chk1(irq, 1'b1);
      rd(OFF_STATUS, 32'h1, 32'h7);
      wr(OFF_IRQ_EN, 32'h0);
      chk1(irq, 1'b0);
      wr(OFF_IRQ_EN, 32'h1);
      wr(OFF_CLEAR, 32'h7);
      chk1(irq, 1'b0);
      wr(OFF_CTRL, 32'h3);
      wr(OFF_START, 32'h0);
      cyc(140);
      chk1(conv_active, 1'b1);
      while (conv_channel != 3'h7) begin
         @(posedge clk_sys);
      end
      chk1(conv_result_meaningful, 1'b1);
      wr(OFF_CTRL, 32'h0);
      // The abort shows one edge after the write commits
      cyc(1);
      chk1(conv_active, 1'b0);
      wr(OFF_CLEAR, 32'h7);
      cyc(70);
      rd(OFF_STATUS, 32'h0, 32'h7);
      $display("software start test done");
   endtask : t_soft

   task t_edge();
      wr(OFF_CTRL, 32'h05);
      wr(OFF_START, 32'h0);
      cyc(70);
      rd(OFF_STATUS, 32'h0, 32'h7);
      pin_cmd[7] <= 1'b0;
      cyc(10);
      chk1(conv_active, 1'b1);
      pin_cmd[7] <= 1'b1;
      cyc(5);
      pin_cmd[7] <= 1'b0;
      cyc(70);
      chk1(conv_active, 1'b0);
      rd(OFF_STATUS, 32'h3, 32'h7);
      wr(OFF_CLEAR, 32'h7);
      wr(OFF_CTRL, 32'h15);
      pin_cmd[7] <= 1'b1;
      cyc(10);
      chk1(conv_active, 1'b1);
      cyc(70);
      rd(OFF_STATUS, 32'h1, 32'h7);
      wr(OFF_CLEAR, 32'h7);
      $display("edge trigger test done");
   endtask : t_edge

   task t_level();
      wr(OFF_CTRL, 32'h1D);
      cyc(10);
      chk1(conv_active, 1'b1);
      pin_cmd[7] <= 1'b0;
      cyc(4);
      pin_cmd[7] <= 1'b1;
      cyc(120);
      chk1(conv_active, 1'b1);
      rd(OFF_STATUS, 32'h1, 32'h7);
      while (conv_channel != 3'h7) begin
         @(posedge clk_sys);
      end
      chk1(conv_result_meaningful, 1'b0);
      pin_cmd[7] <= 1'b0;
      cyc(80);
      chk1(conv_active, 1'b0);
      // Active-low level: the low pin now starts sequences
      wr(OFF_CTRL, 32'h0D);
      cyc(10);
      chk1(conv_active, 1'b1);
      pin_cmd[7] <= 1'b1;
      cyc(80);
      chk1(conv_active, 1'b0);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CLEAR, 32'h7);
      $display("level trigger test done");
   endtask : t_level

   task t_halt(input logic [31:0] ctrl, input bit w);
      wr(OFF_CTRL, ctrl);
      wr(OFF_START, 32'h0);
      cyc(20);
      {stop_mode, wait_mode} <= w ? 2'b01 : 2'b10;
      cyc(2);
      chk1(conv_active, 1'b0);
      cyc(100);
      rd(OFF_STATUS, 32'h200, 32'h207);
      {stop_mode, wait_mode} <= 2'b00;
      cyc(70);
      rd(OFF_STATUS, 32'h5, 32'h7);
      wr(OFF_CLEAR, 32'h7);
      wr(OFF_CTRL, 32'h0);
      $display("halt test done");
   endtask : t_halt

   task t_rst();
      wr(OFF_TRIG_SRC, 32'h2);
      wr(OFF_DIEN, 32'hFF);
      pin_cmd <= 8'h00;
      wr(OFF_CTRL, 32'h3);
      wr(OFF_START, 32'h0);
      cyc(70);
      chk1(irq, 1'b1);
      // Reset rises early in the second scan sequence, still on channel 0
      rst <= 1'b1;
      cyc(6);
      rst <= 1'b0;
      cyc(1);
      chk1(conv_active, 1'b0);
      chk1(irq, 1'b0);
      rd(OFF_CTRL, 32'h0, 32'h3F);
      rd(OFF_TRIG_SRC, 32'h7, 32'h7);
      rd(OFF_PORT, 32'hFF, 32'hFF);
      rd(OFF_STATUS, 32'h0, 32'h7);
      pin_cmd <= 8'hFF;
      $display("mid-run reset test done");
   endtask : t_rst

   task finish_test();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      avs_req = '0;
      pin_cmd = 8'hFF;
      stop_mode = 1'b0;
      wait_mode = 1'b0;
      num_errors = 0;
      cmp_count = 0;
      cyc(6);
      rst <= 1'b0;
      cyc(1);
      t_reset();
      t_soft();
      t_edge();
      t_level();
      t_halt(32'h01, 1'b0);
      t_halt(32'h21, 1'b1);
      t_rst();
      finish_test();
   end

   // Whole run is near 1600 cycles; this bound cuts off a stuck handshake
   initial begin
      repeat (6000) @(posedge clk_sys);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule : tb
`default_nettype wire

// ### design/atc_pkg.sv
// Package for the converter trigger and power control block: map, fields, resets, timing
package atc_pkg;

   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned CLK_MHZ      = CLK_HZ / 1_000_000;
   localparam int unsigned NUM_CH       = 8;

   // Time the digital side holds one channel of a sequence
   localparam int unsigned CONV_TIME_NS = 800;
   localparam int unsigned CONV_CYC     = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned SEQ_CYC      = NUM_CH * CONV_CYC;

   // Byte offsets on the register bus
   localparam logic [4:0] OFF_CTRL     = 5'h00;
   localparam logic [4:0] OFF_TRIG_SRC = 5'h04;
   localparam logic [4:0] OFF_START    = 5'h08;
   localparam logic [4:0] OFF_DIEN     = 5'h0C;
   localparam logic [4:0] OFF_PORT     = 5'h10;
   localparam logic [4:0] OFF_STATUS   = 5'h14;
   localparam logic [4:0] OFF_CLEAR    = 5'h18;
   localparam logic [4:0] OFF_IRQ_EN   = 5'h1C;

   // Event bits shared by status, clear and enable
   localparam int unsigned EV_SEQ_DONE = 0;
   localparam int unsigned EV_OVERRUN  = 1;
   localparam int unsigned EV_RESUMED  = 2;
   localparam int unsigned NUM_EV      = 3;

   // Extra status read bits
   localparam int unsigned STS_BUSY    = 8;
   localparam int unsigned STS_HALTED  = 9;

   localparam int unsigned CTRL_W      = 6;

   typedef struct packed {
      logic wait_halt_bit;
      logic trig_polarity;
      logic trig_level_select;
      logic trig_enable;
      logic scan;
      logic power_up_bit;
   } atc_ctrl_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
   } atc_avs_req_t;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_IDLE,
      ST_CONV
   } atc_state_t;

   localparam atc_ctrl_t         CTRL_RST   = 6'h00;
   localparam logic [2:0]        TRIG_CH_RST = 3'h7;
   localparam logic [7:0]        DIEN_RST   = 8'h00;
   localparam logic [7:0]        PORT_RST   = 8'hFF;
   localparam logic [NUM_EV-1:0] EV_RST     = 3'h0;

endpackage : atc_pkg

// ### design/atc_top.sv
// Trigger selection, conversion sequencing, power control and register slave of the converter
//
// Behaviour
// - Trigger disabled: pin ignored; scan clear one sequence, scan set repeats.
// - Edge mode: one sequence per edge; falling if polarity 0, rising if 1.
// - Level mode: convert continuously while trigger active; polarity picks active level.
// - Trigger taken from channel 7 after reset; source register reassigns it.
// - Edge mode: active edge during a running sequence sets the trigger overrun flag.
// - First conversion starts within one clock of the trigger reaching the logic.
// - Trigger channel result is meaningless while external trigger is enabled.
// - Start register writes do not start conversions while trigger is enabled.
// - Level mode: trigger toggling during a sequence never sets overrun.
// - Level mode: trigger still active at sequence end starts another at once.
// - Pads always feed the analog mux; digital buffers enabled per channel.
// - Stop mode halts conversion; leaving it resumes; that result should be discarded.
// - Wait mode halts conversion when wait halt bit is 1; resumes on exit.
// - Clearing power-up aborts conversion; registers stay accessible.
// - Power-up bit resets to zero: block leaves reset powered down.
// - Sequence-complete interrupt gated by its local enable bit.
// - Port bit reads 1 unless buffer enabled or it is the trigger channel with the trigger enabled.
// - Reset sets every port data bit to 1.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module atc_top
   import atc_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire atc_avs_req_t avs_req,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   input  wire logic [7:0]   an_pin,
   input  wire logic         stop_mode,
   input  wire logic         wait_mode,
   output logic              irq,
   output logic              conv_active,
   output logic [2:0]        conv_channel,
   output logic              conv_result_meaningful
);

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a[4:2] == off[4:2]);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] sync3_q;
   logic [7:0] pin_q;
   logic [7:0] pin_d;
   logic [7:0] port_q;
   logic [7:0] port_d;

   atc_ctrl_t         ctrl_q;
   atc_ctrl_t         ctrl_d;
   logic [2:0]        trig_ch_q;
   logic [2:0]        trig_ch_d;
   logic [7:0]        dien_q;
   logic [7:0]        dien_d;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_pin
         // A change is believed only once two later stages agree
         always_comb begin
            pin_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : pin_q[gi];
            if (dien_q[gi] || (ctrl_q.trig_enable && trig_ch_q == 3'(gi))) begin
               port_d[gi] = pin_q[gi];
            end else begin
               port_d[gi] = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      sync1_q <= an_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (rst) begin
         pin_q  <= PORT_RST;
         port_q <= PORT_RST;
      end else begin
         pin_q  <= pin_d;
         port_q <= port_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register bus

   logic                ack_q;
   logic                ack_d;
   logic [31:0]         rdata_q;
   logic [31:0]         rdata_d;
   logic [NUM_EV-1:0]   status_q;
   logic [NUM_EV-1:0]   status_d;
   logic [NUM_EV-1:0]   irq_en_q;
   logic [NUM_EV-1:0]   irq_en_d;
   logic [NUM_EV-1:0]   ev;
   logic                wr_acc;
   logic                sw_start;
   atc_state_t          state_q;
   logic                halt;

   // Every access takes two cycles: one with waitrequest high, then the answer
   assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign wr_acc          = avs_req.write & ack_q;
   // the start register is deaf while the external trigger owns starts
   assign sw_start        = wr_acc & hit(avs_req.address, OFF_START) & ~ctrl_q.trig_enable;

   always_comb begin
      ack_d     = (avs_req.read | avs_req.write) & ~ack_q;
      rdata_d   = rdata_q;
      ctrl_d    = ctrl_q;
      trig_ch_d = trig_ch_q;
      dien_d    = dien_q;
      irq_en_d  = irq_en_q;
      if (avs_req.read && !ack_q) begin
         rdata_d = 32'h0000_0000;
         if (hit(avs_req.address, OFF_CTRL)) begin
            rdata_d[CTRL_W-1:0] = ctrl_q;
         end else if (hit(avs_req.address, OFF_TRIG_SRC)) begin
            rdata_d[2:0] = trig_ch_q;
         end else if (hit(avs_req.address, OFF_DIEN)) begin
            rdata_d[7:0] = dien_q;
         end else if (hit(avs_req.address, OFF_PORT)) begin
            rdata_d[7:0] = port_q;
         end else if (hit(avs_req.address, OFF_STATUS)) begin
            rdata_d[NUM_EV-1:0] = status_q;
            rdata_d[STS_BUSY]   = (state_q == ST_CONV);
            rdata_d[STS_HALTED] = halt;
         end else if (hit(avs_req.address, OFF_IRQ_EN)) begin
            rdata_d[NUM_EV-1:0] = irq_en_q;
         end
      end
      // all registers stay writable while powered down
      if (wr_acc) begin
         if (hit(avs_req.address, OFF_CTRL)) begin
            ctrl_d = avs_req.writedata[CTRL_W-1:0];
         end else if (hit(avs_req.address, OFF_TRIG_SRC)) begin
            trig_ch_d = avs_req.writedata[2:0];
         end else if (hit(avs_req.address, OFF_DIEN)) begin
            dien_d = avs_req.writedata[7:0];
         end else if (hit(avs_req.address, OFF_IRQ_EN)) begin
            irq_en_d = avs_req.writedata[NUM_EV-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_q     <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         ctrl_q    <= CTRL_RST;
         trig_ch_q <= TRIG_CH_RST;
         dien_q    <= DIEN_RST;
         irq_en_q  <= EV_RST;
      end else begin
         ack_q     <= ack_d;
         rdata_q   <= rdata_d;
         ctrl_q    <= ctrl_d;
         trig_ch_q <= trig_ch_d;
         dien_q    <= dien_d;
         irq_en_q  <= irq_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger detection

   logic trig_raw;
   logic trig_act;
   logic act_prev_q;
   logic trig_edge;
   logic level_mode;
   logic edge_mode;

   assign trig_raw   = pin_q[trig_ch_q];
   // Polarity 0 means falling edge / active low
   assign trig_act   = ctrl_q.trig_polarity ? trig_raw : ~trig_raw;
   assign trig_edge  = trig_act & ~act_prev_q;
   assign level_mode = ctrl_q.trig_enable & ctrl_q.trig_level_select;
   assign edge_mode  = ctrl_q.trig_enable & ~ctrl_q.trig_level_select;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         act_prev_q <= 1'b0;
      end else begin
         act_prev_q <= trig_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer

   localparam logic [5:0] SEQ_LAST = 6'(SEQ_CYC - 1);

   atc_state_t state_d;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic       halt_q;
   logic       start_req;
   logic       restart;

   assign halt = stop_mode | (wait_mode & ctrl_q.wait_halt_bit);

   always_comb begin
      // pin ignored unless enabled; software start only then
      if (ctrl_q.trig_enable) begin
         start_req = level_mode ? trig_act : trig_edge;
      end else begin
         start_req = sw_start;
      end
      if (ctrl_q.trig_enable) begin
         restart = level_mode & trig_act;
      end else begin
         restart = ctrl_q.scan;
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      ev      = '0;
      if (!ctrl_q.power_up_bit) begin
         state_d = ST_OFF;
         cnt_d   = 6'h00;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               state_d = ST_IDLE;
            end
            ST_IDLE: begin
               // A start asked for while halted is dropped, not queued
               if (start_req && !halt) begin
                  state_d = ST_CONV;
                  cnt_d   = 6'h00;
               end
            end
            ST_CONV: begin
               // Level mode never flags overrun, whatever the pin does
               if (edge_mode && trig_edge) begin
                  ev[EV_OVERRUN] = 1'b1;
               end
               if (!halt) begin
                  if (cnt_q == SEQ_LAST) begin
                     ev[EV_SEQ_DONE] = 1'b1;
                     cnt_d           = 6'h00;
                     state_d         = restart ? ST_CONV : ST_IDLE;
                  end else begin
                     cnt_d = cnt_q + 6'h01;
                  end
               end
            end
         endcase
      end
      // Flag the conversion that resumes after a halt so software can drop it
      if (state_q == ST_CONV && halt_q && !halt && ctrl_q.power_up_bit) begin
         ev[EV_RESUMED] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_OFF;
         cnt_q   <= 6'h00;
         halt_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         halt_q  <= halt;
      end
   end

   assign conv_active  = (state_q == ST_CONV) & ~halt;
   // the mux follows the sequence regardless of the digital buffers
   assign conv_channel = 3'(cnt_q / 6'(CONV_CYC));
   assign conv_result_meaningful = ~(ctrl_q.trig_enable & (conv_channel == trig_ch_q));

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status

   logic [NUM_EV-1:0] clr;

   assign clr = (wr_acc && hit(avs_req.address, OFF_CLEAR)) ? avs_req.writedata[NUM_EV-1:0] : '0;

   always_comb begin
      // A new event wins over a clear in the same cycle
      status_d = (status_q & ~clr) | ev;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         status_q <= EV_RST;
      end else begin
         status_q <= status_d;
      end
   end

   // Processor-side masking is done outside this block
   assign irq = |(status_q & irq_en_q);

endmodule : atc_top

`default_nettype wire
